// ==== hw/arts_pkg.sv ====
// Constants and types shared by the conversion result and time stamp block.
// Assumes a single core clock domain; this file holds no logic.
package arts_pkg;

    // Channel count and field widths
    localparam int ARTS_NUM_CH    = 4;
    localparam int ARTS_CODE_W    = 10;
    localparam int ARTS_STAMP_W   = 6;
    localparam int ARTS_REG_W     = 16;
    localparam int ARTS_CH_IDX_W  = 2;

    // Field positions inside every result register
    localparam int ARTS_CODE_LSB  = 0;
    localparam int ARTS_CODE_MSB  = 9;
    localparam int ARTS_STAMP_LSB = 10;
    localparam int ARTS_STAMP_MSB = 15;

    // Counter limits
    localparam logic [5:0] ARTS_STAMP_MAX  = 6'h3F;
    localparam logic [5:0] ARTS_STAMP_ZERO = 6'h00;
    localparam logic [5:0] ARTS_STAMP_STEP = 6'h01;

    // Reset values
    localparam logic [15:0] ARTS_RESULT_RST = 16'h0000;
    localparam logic [9:0]  ARTS_CODE_RST   = 10'h000;
    localparam logic [5:0]  ARTS_STAMP_RST  = 6'h00;

    // Scale of one code step, for software conversion only
    localparam real ARTS_MV_PER_STEP   = 3.519;
    localparam real ARTS_DEGC_PER_STEP = 0.7015;
    localparam real ARTS_DEGC_OFFSET   = 198.36;

    // Channel index, also the read selector index of its result register
    typedef enum logic [1:0] {
        ARTS_CH_AIN_FOUR = 2'h0,
        ARTS_CH_AIN_SIX  = 2'h1,
        ARTS_CH_DIE_TEMP = 2'h2,
        ARTS_CH_GATE_TH  = 2'h3
    } arts_chan_type;

endpackage : arts_pkg

// ==== hw/arts_slot_if.sv ====
// Carrier between the top and one result slot.
// Assumes both ends run on core_clk_in.
`timescale 1ns/100ps
interface arts_slot_if;
    import arts_pkg::*;
    logic                    capture;  // One-cycle capture strobe
    logic [ARTS_STAMP_W-1:0] stamp;    // Counter value to latch
    logic [ARTS_CODE_W-1:0]  code;     // Conversion code to latch
    logic [ARTS_REG_W-1:0]   value;    // Assembled register image

    modport owner (output capture, output stamp, output code, input value);
    modport slot  (input capture, input stamp, input code, output value);
endinterface : arts_slot_if

// ==== hw/arts_edge_detect.sv ====
// Two-stage synchroniser and any-edge detector for the drive input pin.
// Assumes the pin is asynchronous to core_clk_in and slower than it, and
// that reset is held at least three clocks so the chain tracks the pin.
`timescale 1ns/100ps
module arts_edge_detect
    import arts_pkg::*;
(
    input  wire logic core_clk_in,   // Core clock
    input  wire logic nrst_in,       // Sync reset, active low
    input  wire logic pin_in,        // Raw drive input pin
    output logic      level_out,     // Synchronised level
    output logic      edge_out       // Pulse on either edge
);

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic prev;
    } arts_edge_state_type;

    arts_edge_state_type state_r;
    arts_edge_state_type state_nxt;

    always_comb begin
        state_nxt        = state_r;
        state_nxt.sync_a = pin_in;
        state_nxt.sync_b = state_r.sync_a;
        state_nxt.prev   = state_r.sync_b;
    end

    // Chain keeps sampling through reset, so a pin idling high
    // shows no false edge on release
    always_ff @(posedge core_clk_in) begin
        state_r <= state_nxt;
    end

    assign level_out = state_r.sync_b;
    // Rising and falling both count; nothing reported while in reset
    assign edge_out  = nrst_in & (state_r.sync_b ^ state_r.prev);   // see R1

endmodule : arts_edge_detect

// ==== hw/arts_result_slot.sv ====
// One result register: stamp field over conversion code field.
// Assumes the owner raises capture for one cycle per valid conversion.
`timescale 1ns/100ps
module arts_result_slot
    import arts_pkg::*;
(
    input  wire logic     core_clk_in,   // Core clock
    input  wire logic     nrst_in,       // Sync reset, active low
    arts_slot_if.slot     port_if        // Capture in, image out
);

    typedef struct packed {
        logic [ARTS_STAMP_W-1:0] stamp;
        logic [ARTS_CODE_W-1:0]  code;
    } arts_slot_state_type;

    arts_slot_state_type state_r;
    arts_slot_state_type state_nxt;

    // Both fields move on one strobe so a read never mixes conversions
    always_comb begin
        state_nxt = state_r;
        if (port_if.capture) begin
            state_nxt.stamp = port_if.stamp;   // see R3
            state_nxt.code  = port_if.code;    // see R4
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_r.stamp <= ARTS_STAMP_RST;
            state_r.code  <= ARTS_CODE_RST;
        end else begin
            state_r <= state_nxt;              // see R9
        end
    end

    assign port_if.value[ARTS_STAMP_MSB:ARTS_STAMP_LSB] = state_r.stamp;
    assign port_if.value[ARTS_CODE_MSB:ARTS_CODE_LSB]   = state_r.code;

endmodule : arts_result_slot

// ==== hw/adc_result_timestamp_regs.sv ====
// Conversion result registers with drive-edge time stamps, four sources.
// Assumes the conversion engine runs on core_clk_in and gives one-cycle
// done strobes; the serial register engine reads the images below.
`timescale 1ns/100ps

// Summary of operation
// R1 - Stamp counter steps on both drive edges
// R2 - Counter wraps from 63 to zero
// R3 - Input four stamp latched only on valid conversion
// R4 - Input four low bits hold latest code
// R5 - Input six stamp and code latched together
// R6 - Die temperature code kept in low bits
// R7 - Die temperature stamp latched on its conversion
// R8 - Gate threshold code and stamp latched on conversion
// R9 - Stamp and code update in same cycle
module adc_result_timestamp_regs
    import arts_pkg::*;
(
    input  wire logic                     core_clk_in,           // Core clock, 50 MHz
    input  wire logic                     nrst_in,               // Sync reset, active low
    input  wire logic                     drive_input_positive_in, // Drive input pin
    input  wire logic                     conv_valid_in,         // Valid conversion done
    input  wire logic [ARTS_CH_IDX_W-1:0] conv_chan_in,          // Channel of that result
    input  wire logic [ARTS_CODE_W-1:0]   conv_code_in,          // Conversion code
    input  wire logic                     read_req_in,           // Register read strobe
    input  wire logic [ARTS_CH_IDX_W-1:0] read_sel_in,           // Register index to read
    output logic      [ARTS_REG_W-1:0]    read_data_out,         // Read image, registered
    output logic                          read_valid_out,        // Read data valid pulse
    output logic      [ARTS_REG_W-1:0]    ain_four_result_out,   // Input four result
    output logic      [ARTS_REG_W-1:0]    ain_six_result_out,    // Input six result
    output logic      [ARTS_REG_W-1:0]    die_temperature_result_out, // Die temp result
    output logic      [ARTS_REG_W-1:0]    gate_threshold_result_out,  // Gate level result
    output logic      [ARTS_STAMP_W-1:0]  stamp_count_out,       // Live stamp counter
    output logic                          drive_level_out        // Synchronised drive level
);

    typedef struct packed {
        logic [ARTS_STAMP_W-1:0] stamp_cnt;
        logic [ARTS_REG_W-1:0]   rd_data;
        logic                    rd_valid;
    } arts_top_state_type;

    arts_top_state_type state_r;
    arts_top_state_type state_nxt;

    logic                  drive_edge;
    logic                  drive_level;
    logic [ARTS_REG_W-1:0] result_img [ARTS_NUM_CH];
    logic [ARTS_NUM_CH-1:0] cap_sel;

    arts_edge_detect u_edge (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .pin_in      (drive_input_positive_in),
        .level_out   (drive_level),
        .edge_out    (drive_edge)
    );

    // One slot per source; the stamp is the count held before this edge,
    // so a conversion and an edge in one cycle keep the older value.
    genvar ch;
    generate
        for (ch = 0; ch < ARTS_NUM_CH; ch++) begin : g_slot
            arts_slot_if slot_if ();

            assign cap_sel[ch] = conv_valid_in
                                 && (conv_chan_in == ARTS_CH_IDX_W'(ch)); // see R3 R5 R7 R8
            assign slot_if.capture = cap_sel[ch];
            assign slot_if.stamp   = state_r.stamp_cnt;
            assign slot_if.code    = conv_code_in;          // see R4 R6
            assign result_img[ch]  = slot_if.value;

            arts_result_slot u_slot (
                .core_clk_in (core_clk_in),
                .nrst_in     (nrst_in),
                .port_if     (slot_if)
            );
        end
    endgenerate

    always_comb begin
        state_nxt = state_r;
        if (drive_edge) begin
            // Natural 6-bit rollover, written out for clarity
            if (state_r.stamp_cnt == ARTS_STAMP_MAX) begin
                state_nxt.stamp_cnt = ARTS_STAMP_ZERO;                     // see R2
            end else begin
                state_nxt.stamp_cnt = state_r.stamp_cnt + ARTS_STAMP_STEP; // see R1
            end
        end
        state_nxt.rd_valid = read_req_in;
        if (read_req_in) begin
            // Every 2-bit index is mapped, so no unmapped answer exists
            state_nxt.rd_data = result_img[read_sel_in];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_r.stamp_cnt <= ARTS_STAMP_RST;
            state_r.rd_data   <= ARTS_RESULT_RST;
            state_r.rd_valid  <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign read_data_out              = state_r.rd_data;
    assign read_valid_out             = state_r.rd_valid;
    assign ain_four_result_out        = result_img[ARTS_CH_AIN_FOUR];
    assign ain_six_result_out         = result_img[ARTS_CH_AIN_SIX];
    assign die_temperature_result_out = result_img[ARTS_CH_DIE_TEMP];
    assign gate_threshold_result_out  = result_img[ARTS_CH_GATE_TH];
    assign stamp_count_out            = state_r.stamp_cnt;
    assign drive_level_out            = drive_level;

endmodule : adc_result_timestamp_regs

// ==== tb/arts_chk_assertions.sv ====
// Checker bound to the result block top.
// Assumes one clock and a sync active low reset.
`timescale 1ns/100ps
module arts_chk (
    input wire logic        core_clk_in, // clock
    input wire logic        nrst_in, // reset
    input wire logic        conv_valid_in, // done
    input wire logic [1:0]  conv_chan_in, // slot
    input wire logic [9:0]  conv_code_in, // code
    input wire logic [15:0] ain_four_result_out, // slot 0
    input wire logic [15:0] ain_six_result_out, // slot 1
    input wire logic [15:0] die_temperature_result_out, // slot 2
    input wire logic [15:0] gate_threshold_result_out, // slot 3
    input wire logic [5:0]  stamp_count_out, // count
    input wire logic        drive_level_out // level
);
    logic [15:0] cap_r;
    always_ff @(posedge core_clk_in) cap_r <= {stamp_count_out, conv_code_in};
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    chk_count_step: assert property ($changed(stamp_count_out) |->
        stamp_count_out == $past(stamp_count_out) + 6'h01) else $error("bad step");
    chk_count_wrap: assert property ($past(stamp_count_out) == 6'h3F &&
        $changed(stamp_count_out) |-> stamp_count_out == 6'h00) else $error("bad wrap");
    chk_edge_counted: assert property ($changed(drive_level_out) |=>
        $changed(stamp_count_out)) else $error("edge lost");
    chk_four_hold: assert property (!(conv_valid_in && conv_chan_in == 2'h0) |=>
        $stable(ain_four_result_out)) else $error("four moved");
    chk_four_load: assert property (conv_valid_in && conv_chan_in == 2'h0 |=>
        ain_four_result_out == cap_r) else $error("four load");
    chk_six_load: assert property (conv_valid_in && conv_chan_in == 2'h1 |=>
        ain_six_result_out == cap_r) else $error("six load");
    chk_temp_load: assert property (conv_valid_in && conv_chan_in == 2'h2 |=>
        die_temperature_result_out == cap_r) else $error("temp load");
    chk_gate_load: assert property (conv_valid_in && conv_chan_in == 2'h3 |=>
        gate_threshold_result_out == cap_r) else $error("gate load");
endmodule : arts_chk
bind adc_result_timestamp_regs arts_chk arts_chk_i (.core_clk_in, .nrst_in,
    .conv_valid_in, .conv_chan_in, .conv_code_in, .ain_four_result_out,
    .ain_six_result_out, .die_temperature_result_out, .gate_threshold_result_out,
    .stamp_count_out, .drive_level_out);

// ==== tb/arts_host.sv ====
// Host model issuing register reads.
// Assumes data answers one cycle after the request.
`timescale 1ns/100ps
module arts_host (
    input  wire logic        clk_in, // clock
    output logic             req_out, // read strobe
    output logic [1:0]       sel_out, // register index
    input  wire logic [15:0] data_in, // read image
    input  wire logic        valid_in // read done
);
    initial req_out = 1'b0;
    initial sel_out = 2'h0;
    task automatic rd(input logic [1:0] sel, output logic [15:0] d, output bit ok);
        req_out = 1'b1;
        sel_out = sel;
        @(posedge clk_in) #1;
        req_out = 1'b0;
        sel_out = ~sel; // Idle index moves, so a stale decode shows
        ok = (valid_in === 1'b1);
        d = data_in;
        @(posedge clk_in) #1;
    endtask : rd
endmodule : arts_host

// ==== tb/tb_adc_result_timestamp_regs.sv ====
// Bench for the result and stamp block.
// Assumes the host model owns the read port.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_adc_result_timestamp_regs;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        pin = 1'b0;
    logic        cv = 1'b0;
    logic [1:0]  ch = 2'h0;
    logic [9:0]  code = 10'h000;
    logic        req;
    logic [1:0]  sel;
    logic        rvalid;
    logic [15:0] rdata, r0, r1, r2, r3;
    logic [5:0]  cnt = 6'h00;
    logic [5:0]  stamp;
    logic        level;
    logic [15:0] exp [4] = '{4{16'h0000}};
    int          fails = 0;
    int          cmp_count = 0;
    adc_result_timestamp_regs adc_result_timestamp_regs_i (.core_clk_in(clk),
        .nrst_in(nrst), .drive_input_positive_in(pin), .conv_valid_in(cv),
        .conv_chan_in(ch), .conv_code_in(code), .read_req_in(req), .read_sel_in(sel),
        .read_data_out(rdata), .read_valid_out(rvalid), .ain_four_result_out(r0),
        .ain_six_result_out(r1), .die_temperature_result_out(r2),
        .gate_threshold_result_out(r3), .stamp_count_out(stamp), .drive_level_out(level));
    arts_host arts_host_i (.clk_in(clk), .req_out(req), .sel_out(sel),
        .data_in(rdata), .valid_in(rvalid));
    initial forever #10 clk = ~clk;
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic check_all;
        logic [15:0] d;
        bit          ok;
        for (int i = 0; i < 4; i++) begin
            arts_host_i.rd(i[1:0], d, ok);
            `CHK(ok, 1'b1)
            if (!ok) end_sim();
            `CHK(d, exp[i])
        end
        `CHK({r3, r2, r1, r0}, {exp[3], exp[2], exp[1], exp[0]})
    endtask : check_all
    task automatic toggle(input int n); // Edges 3 clocks apart so none merge
        repeat (n) begin
            pin = ~pin;
            cnt++;
            repeat (3) @(posedge clk) #1;
        end
        repeat (2) @(posedge clk) #1;
        `CHK(stamp, cnt)
        `CHK(level, pin)
    endtask : toggle
    task automatic burst(input logic [1:0] first, input int n);
        cv = 1'b1;
        for (int i = 0; i < n; i++) begin
            ch = first + i[1:0];
            code = 10'h3FF ^ {5{ch}};
            exp[ch] = {cnt, code};
            @(posedge clk) #1;
        end
        cv = 1'b0;
        @(posedge clk) #1;
        check_all();
    endtask : burst
    task automatic test_reset; // Also used mid-run, pin possibly high
        nrst = 1'b0;
        repeat (4) @(posedge clk) #1;
        nrst = 1'b1;
        cnt = 6'h00;
        exp = '{4{16'h0000}};
        check_all();
        `CHK(stamp, 6'h00)
        $display("test reset done");
    endtask : test_reset
    task automatic test_burst;
        toggle(5);
        burst(2'h0, 4);
        $display("test burst done");
    endtask : test_burst
    task automatic test_wrap;
        toggle(58);
        burst(2'h1, 1);
        toggle(1);
        burst(2'h2, 1);
        $display("test wrap done");
    endtask : test_wrap
    task automatic test_same_edge; // Conversion on the counting edge keeps old count
        pin = ~pin;
        repeat (2) @(posedge clk) #1;
        cv = 1'b1;
        ch = 2'h3;
        code = 10'h0A5;
        exp[3] = {cnt, code};
        cnt++;
        @(posedge clk) #1;
        cv = 1'b0;
        repeat (2) @(posedge clk) #1;
        check_all();
        `CHK(stamp, cnt)
        $display("test same edge done");
    endtask : test_same_edge
    initial begin
        test_reset();
        test_burst();
        test_wrap();
        test_same_edge();
        test_reset();
        end_sim();
    end
endmodule : tb_adc_result_timestamp_regs
